/* hdl/eep_buf2.sv */
// Purpose: Small valid/ready buffer, two entries by default.
// Assumes: Both sides run on the same clock.
// Notes: Full and empty are exact; in_ready drops when every entry is taken.
`timescale 1ns/10ps
`default_nettype none

module eep_buf2 #(
   parameter int W = 24,
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [W-1:0] mem_r [DEPTH];
   logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [PW:0] cnt_r, cnt_nxt;
   logic push, pop;

   // Handshake terms and pointer advance with wrap at the depth.
   always_comb
   begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      wp_nxt = push ? ((wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + 1'b1) : wp_r;
      rp_nxt = pop ? ((rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + 1'b1) : rp_r;
      cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
   end

   assign in_ready = (cnt_r != (PW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem_r[rp_r];

   // Pointers and fill count.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Storage needs no reset; an entry is only read once written.
   always_ff @(posedge clk)
   begin
      if (push)
         mem_r[wp_r] <= in_data;
   end

endmodule // eep_buf2

`default_nettype wire

/* hdl/eep_core.sv */
// Purpose: Device side of a 16 x 16 serial EEPROM with ready/busy on the data output.
// Assumes: serial_clock is the link clock and only toggles while chip_sel is high.
// Notes: The array and the programming timer live on sys_clk; the shifter on serial_clock.
// Functional notes
// - Output floats while bits shift in.
// - Read drives low dummy bit after address.
// - Last address bit captured before dummy drives.
// - Sixteen words of sixteen bits.
// - Programming starts at chip select fall.
// - Status shown after select high 1 us.
// - Status low while busy, high when done.
// - Clocked-in one with select high cancels status.
// - Select low clears instruction register.
// - Power-up may show ready status.
`timescale 1ns/10ps
`default_nettype none

module eep_core
   import eep_pkg::*;
#(
   parameter int ADDR_BITS = `EEP_ADDR_BITS,
   parameter int PROG_CYC = `EEP_T_PROG_MS * `EEP_SYS_MHZ * 1000
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic serial_clock,
   input wire logic chip_sel,
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_out_oe_b,
   output logic prog_busy
);
   localparam int CS_CYC = (`EEP_T_CS_NS * `EEP_SYS_MHZ + 999) / 1000;
   localparam int PCW = $clog2(PROG_CYC + 1);

   // Link side state.
   eep_lstate_t lst_r, lst_nxt;
   logic [4:0] bcnt_r, bcnt_nxt;
   logic [1:0] op_r, op_nxt;
   logic [ADDR_BITS-1:0] addr_r, addr_nxt;
   logic [`EEP_WORD_W-1:0] sh_r, sh_nxt;
   logic rd_drive_r, rd_drive_nxt, rd_bit_r, rd_bit_nxt;
   eep_cmd_t cmd_r, cmd_nxt;
   logic [`EEP_IDX_W-1:0] rd_addr_r, rd_addr_nxt;
   logic cmd_tgl_r, cmd_tgl_nxt, rdq_tgl_r, rdq_tgl_nxt, can_tgl_r, can_tgl_nxt;
   logic wen_r, wen_nxt;
   logic link_rst_b;
   logic [ADDR_BITS-1:0] addr_full;
   logic [`EEP_WORD_W-1:0] data_full;
   logic issue;

   // System side state.
   logic [5:0] sy1_r, sy2_r, sy3_r;
   logic cs_s, drv_s, bit_s, cs_fall, cmd_p, rdq_p, can_p;
   logic [6:0] cs_cnt_r, cs_cnt_nxt;
   logic pend_r, pend_nxt, arm_r, arm_nxt, busy_r, busy_nxt, stat_r, stat_nxt;
   logic [PCW-1:0] pcnt_r, pcnt_nxt;
   eep_cmd_t pcmd_r, pcmd_nxt, bo_data;
   logic so_r, so_nxt, soe_r, soe_nxt, show;
   logic b_in_ready, b_out_valid, start, done;
   logic [`EEP_WORD_W-1:0] mem_r [`EEP_WORDS];
   logic [`EEP_WORD_W-1:0] rd_word_r;

   // Frame logic is held in reset while select is low, which clears the
   // instruction register without needing a clock edge.
   assign link_rst_b = rst_b & chip_sel;
   assign addr_full = {addr_r[ADDR_BITS-2:0], serial_in};
   assign data_full = {sh_r[`EEP_WORD_W-2:0], serial_in};

   // Serial decoder; each rising link edge takes one input bit.
   always_comb
   begin
      lst_nxt = lst_r;
      bcnt_nxt = bcnt_r;
      op_nxt = op_r;
      addr_nxt = addr_r;
      sh_nxt = sh_r;
      rd_drive_nxt = rd_drive_r;
      rd_bit_nxt = rd_bit_r;
      cmd_nxt = cmd_r;
      rd_addr_nxt = rd_addr_r;
      rdq_tgl_nxt = rdq_tgl_r;
      can_tgl_nxt = can_tgl_r;
      wen_nxt = wen_r;
      issue = 1'b0;
      unique case (lst_r)
         EEP_L_IDLE:
         begin
            if (serial_in)
            begin
               can_tgl_nxt = ~can_tgl_r;
               lst_nxt = EEP_L_OP;
               bcnt_nxt = '0;
            end
         end
         EEP_L_OP:
         begin
            op_nxt = {op_r[0], serial_in};
            bcnt_nxt = bcnt_r + 5'h01;
            if (bcnt_r == 5'h01)
            begin
               lst_nxt = EEP_L_ADDR;
               bcnt_nxt = '0;
            end
         end
         EEP_L_ADDR:
         begin
            addr_nxt = addr_full;
            bcnt_nxt = bcnt_r + 5'h01;
            if (bcnt_r == 5'(ADDR_BITS - 1))
            begin
               bcnt_nxt = '0;
               lst_nxt = EEP_L_DONE;
               if (op_r == `EEP_OP_READ)
               begin
                  // Address is complete before the pin is driven.
                  rd_addr_nxt = addr_full[`EEP_IDX_W-1:0];
                  rdq_tgl_nxt = ~rdq_tgl_r;
                  rd_drive_nxt = 1'b1;
                  rd_bit_nxt = 1'b0;
                  lst_nxt = EEP_L_READ;
               end
               else if (op_r == `EEP_OP_WRITE)
                  lst_nxt = EEP_L_DATA;
               else if (op_r == `EEP_OP_ERASE)
                  issue = wen_r;
               else
               begin
                  unique case (addr_full[ADDR_BITS-1 -: 2])
                     `EEP_SUB_ENABLE: wen_nxt = 1'b1;
                     `EEP_SUB_DISABLE: wen_nxt = 1'b0;
                     `EEP_SUB_ERALL: issue = wen_r;
                     `EEP_SUB_WRALL: lst_nxt = EEP_L_DATA;
                  endcase
               end
            end
         end
         EEP_L_DATA:
         begin
            sh_nxt = data_full;
            bcnt_nxt = bcnt_r + 5'h01;
            if (bcnt_r == 5'(`EEP_WORD_W - 1))
            begin
               issue = wen_r;
               lst_nxt = EEP_L_DONE;
            end
         end
         EEP_L_READ:
         begin
            // The word is loaded one link period after the request, which
            // relies on the system side answering within that period.
            bcnt_nxt = bcnt_r + 5'h01;
            if (bcnt_r == 5'h00)
            begin
               rd_bit_nxt = rd_word_r[`EEP_WORD_W-1];
               sh_nxt = {rd_word_r[`EEP_WORD_W-2:0], 1'b0};
            end
            else if (bcnt_r == 5'(`EEP_WORD_W))
            begin
               rd_drive_nxt = 1'b0;
               lst_nxt = EEP_L_DONE;
            end
            else
            begin
               rd_bit_nxt = sh_r[`EEP_WORD_W-1];
               sh_nxt = {sh_r[`EEP_WORD_W-2:0], 1'b0};
            end
         end
         EEP_L_DONE:
            lst_nxt = EEP_L_DONE;
         default:
            lst_nxt = EEP_L_IDLE;
      endcase
      cmd_tgl_nxt = cmd_tgl_r ^ issue;
      if (issue)
         cmd_nxt = '{op: op_r, addr: addr_nxt, data: sh_nxt};
   end

   // Frame registers, cleared whenever select is low.
   always_ff @(posedge serial_clock or negedge link_rst_b)
   begin
      if (!link_rst_b)
      begin
         lst_r <= EEP_L_IDLE;
         bcnt_r <= '0;
         op_r <= '0;
         addr_r <= '0;
         sh_r <= '0;
         rd_drive_r <= 1'b0;
         rd_bit_r <= 1'b0;
      end
      else
      begin
         lst_r <= lst_nxt;
         bcnt_r <= bcnt_nxt;
         op_r <= op_nxt;
         addr_r <= addr_nxt;
         sh_r <= sh_nxt;
         rd_drive_r <= rd_drive_nxt;
         rd_bit_r <= rd_bit_nxt;
      end
   end

   // Registers that outlive a frame: handoff words, toggles, write enable.
   always_ff @(posedge serial_clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cmd_r <= '0;
         rd_addr_r <= '0;
         cmd_tgl_r <= 1'b0;
         rdq_tgl_r <= 1'b0;
         can_tgl_r <= 1'b0;
         wen_r <= 1'b0;
      end
      else
      begin
         cmd_r <= cmd_nxt;
         rd_addr_r <= rd_addr_nxt;
         cmd_tgl_r <= cmd_tgl_nxt;
         rdq_tgl_r <= rdq_tgl_nxt;
         can_tgl_r <= can_tgl_nxt;
         wen_r <= wen_nxt;
      end
   end

   // Two-stage synchronisers into sys_clk, one per crossing control bit; a third
   // stage gives the previous value for edge and toggle detection.
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++)
      begin : g_sync
         logic src;
         assign src = (gi == 0) ? chip_sel : (gi == 1) ? rd_drive_r : (gi == 2) ? rd_bit_r :
                      (gi == 3) ? cmd_tgl_r : (gi == 4) ? rdq_tgl_r : can_tgl_r;
         always_ff @(posedge sys_clk or negedge rst_b)
         begin
            if (!rst_b)
            begin
               sy1_r[gi] <= 1'b0;
               sy2_r[gi] <= 1'b0;
               sy3_r[gi] <= 1'b0;
            end
            else
            begin
               sy1_r[gi] <= src;
               sy2_r[gi] <= sy1_r[gi];
               sy3_r[gi] <= sy2_r[gi];
            end
         end
      end
   endgenerate

   assign cs_s = sy2_r[0];
   assign drv_s = sy2_r[1];
   assign bit_s = sy2_r[2];
   assign cs_fall = sy3_r[0] & ~sy2_r[0];
   assign cmd_p = sy3_r[3] ^ sy2_r[3];
   assign rdq_p = sy3_r[4] ^ sy2_r[4];
   assign can_p = sy3_r[5] ^ sy2_r[5];

   // Commands wait here if the engine is still busy with the previous one.
   eep_buf2 #(
      .W($bits(eep_cmd_t)),
      .DEPTH(2)
   ) u_cmd_buf (
      .clk(sys_clk),
      .rst_b(rst_b),
      .in_valid(pend_r),
      .in_ready(b_in_ready),
      .in_data(cmd_r),
      .out_valid(b_out_valid),
      .out_ready(start),
      .out_data(bo_data)
   );

   // Programming engine, status flag and pin driver.
   always_comb
   begin
      pend_nxt = (pend_r && !b_in_ready) || cmd_p;
      arm_nxt = arm_r;
      if (cs_fall)
         arm_nxt = 1'b1;
      start = arm_r && b_out_valid && !busy_r && !cs_s;
      if (start || cs_s)
         arm_nxt = 1'b0;
      done = busy_r && (pcnt_r == PCW'(1));
      busy_nxt = start || (busy_r && !done);
      pcnt_nxt = start ? PCW'(PROG_CYC) : (busy_r ? pcnt_r - 1'b1 : pcnt_r);
      pcmd_nxt = start ? bo_data : pcmd_r;
      // A new programming start wins over a cancel in the same cycle.
      stat_nxt = start || (stat_r && !can_p);
      cs_cnt_nxt = !cs_s ? '0 : ((cs_cnt_r == 7'(CS_CYC)) ? cs_cnt_r : cs_cnt_r + 7'h01);
      show = stat_r && cs_s && (cs_cnt_r == 7'(CS_CYC));
      if (drv_s)
      begin
         soe_nxt = 1'b0;
         so_nxt = bit_s;
      end
      else if (show)
      begin
         soe_nxt = 1'b0;
         so_nxt = !busy_r;
      end
      else
      begin
         soe_nxt = 1'b1;
         so_nxt = 1'b0;
      end
   end

   // Status flag starts set so that a fresh device may show ready.
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pend_r <= 1'b0;
         arm_r <= 1'b0;
         busy_r <= 1'b0;
         pcnt_r <= '0;
         pcmd_r <= '0;
         stat_r <= 1'b1;
         cs_cnt_r <= '0;
         so_r <= 1'b0;
         soe_r <= 1'b1;
         prog_busy <= 1'b0;
      end
      else
      begin
         pend_r <= pend_nxt;
         arm_r <= arm_nxt;
         busy_r <= busy_nxt;
         pcnt_r <= pcnt_nxt;
         pcmd_r <= pcmd_nxt;
         stat_r <= stat_nxt;
         cs_cnt_r <= cs_cnt_nxt;
         so_r <= so_nxt;
         soe_r <= soe_nxt;
         prog_busy <= busy_nxt;
      end
   end

   assign serial_out = so_r;
   assign serial_out_oe_b = soe_r;

   // Array words commit at the end of the self-timed cycle.
   generate
      for (gi = 0; gi < `EEP_WORDS; gi++)
      begin : g_word
         logic hit, all;
         assign hit = pcmd_r.addr[`EEP_IDX_W-1:0] == `EEP_IDX_W'(gi);
         assign all = pcmd_r.op == `EEP_OP_SPECIAL;
         always_ff @(posedge sys_clk)
         begin
            if (done && (hit || all))
               mem_r[gi] <= (pcmd_r.op == `EEP_OP_ERASE ||
                             (all && pcmd_r.addr[ADDR_BITS-1 -: 2] == `EEP_SUB_ERALL)) ?
                            `EEP_ERASED : pcmd_r.data;
         end
      end
   endgenerate

   // Read word fetched on request; the link side samples it a period later.
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         rd_word_r <= '0;
      else if (rdq_p)
         rd_word_r <= mem_r[rd_addr_r];
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   a_float_idle: assert property ((!drv_s && !show) |=> serial_out_oe_b)
      else $error("output driven while shifting in");
   a_dummy_low: assert property ($rose(drv_s) |=> (!serial_out_oe_b && !serial_out))
      else $error("dummy bit not driven low");
   a_start_fall: assert property ($rose(busy_r) |-> ($past(arm_r) && !$past(cs_s)))
      else $error("programming started without select fall");
   a_status_wait: assert property ((!serial_out_oe_b && !$past(drv_s, 1)) |-> $past(cs_cnt_r) == 7'(CS_CYC))
      else $error("status shown before select high time");
   a_status_val: assert property ((!serial_out_oe_b && !$past(drv_s, 1)) |-> serial_out == !$past(busy_r))
      else $error("status level wrong");
   a_prog_end: assert property ((busy_r && pcnt_r == PCW'(1)) |=> (!busy_r && !prog_busy))
      else $error("programming did not end on count");
   a_cancel_stat: assert property ((can_p && !start) |=> !stat_r)
      else $error("status not cancelled");
   a_sel_low: assert property ((!cs_s)[*4] |-> ##1 serial_out_oe_b)
      else $error("output driven with select low");
   a_mem_write: assert property ((done && pcmd_r.op == `EEP_OP_WRITE) |=>
      mem_r[$past(pcmd_r.addr[3:0])] == $past(pcmd_r.data))
      else $error("word not written");
   a_addr_first: assert property (@(posedge serial_clock) disable iff (!link_rst_b)
      $rose(rd_drive_r) |-> (lst_r == EEP_L_READ && rd_addr_r == addr_r[`EEP_IDX_W-1:0]))
      else $error("drive before address capture");

   c_read: cover property ($rose(drv_s) ##[1:200] $fell(drv_s));
   c_prog: cover property ($rose(busy_r) ##1 busy_r);
   c_ready: cover property (show && !busy_r ##1 can_p);
   c_powerup: cover property (stat_r && show);

endmodule // eep_core

`default_nettype wire

/* hdl/eep_defines.svh */
// Purpose: Shared constants of the serial EEPROM device model.
// Assumes: System clock of 50 MHz; link clock is the serial clock pin.
// Notes: Opcodes sit in the two bits that follow the start bit.
`ifndef EEP_DEFINES_SVH
`define EEP_DEFINES_SVH

// Word organisation of the array.
`define EEP_WORDS 16
`define EEP_WORD_W 16
`define EEP_IDX_W 4
`define EEP_ADDR_BITS 6
`define EEP_ERASED 16'hffff

// Main opcodes that follow the start bit.
`define EEP_OP_SPECIAL 2'b00
`define EEP_OP_WRITE 2'b01
`define EEP_OP_READ 2'b10
`define EEP_OP_ERASE 2'b11

// Sub-opcodes in the two upper address bits when the main opcode is special.
`define EEP_SUB_DISABLE 2'b00
`define EEP_SUB_WRALL 2'b01
`define EEP_SUB_ERALL 2'b10
`define EEP_SUB_ENABLE 2'b11

// Timing figures and the system clock rate.
`define EEP_SYS_MHZ 50
`define EEP_T_CS_NS 1000
`define EEP_T_PROG_MS 30

`endif

/* hdl/eep_pkg.sv */
// Purpose: Types shared by the serial EEPROM device files.
// Assumes: Constants come from the defines header.
// Notes: The command struct crosses from the link side to the system side.
`include "eep_defines.svh"

package eep_pkg;

   // States of the serial shifter on the link clock.
   typedef enum logic [2:0] {
      EEP_L_IDLE = 3'b000,
      EEP_L_OP   = 3'b001,
      EEP_L_ADDR = 3'b010,
      EEP_L_DATA = 3'b011,
      EEP_L_READ = 3'b100,
      EEP_L_DONE = 3'b101
   } eep_lstate_t;

   // One programming command as the programming engine receives it.
   typedef struct packed {
      logic [1:0] op;
      logic [`EEP_ADDR_BITS-1:0] addr;
      logic [`EEP_WORD_W-1:0] data;
   } eep_cmd_t;

endpackage

/* verification/eep_core_test.sv */
// Purpose: Self-checking bench for the serial EEPROM core.
// Assumes: Programming time shortened to 200 system cycles.
// Notes: All link traffic comes from the host model.
`timescale 1ns/10ps
`default_nettype none
`include "eep_defines.svh"

module eep_core_test;
   localparam int PROG = 200;
   logic sys_clk;
   logic rst_b;
   logic serial_clock;
   logic chip_sel;
   logic serial_in;
   logic serial_out;
   logic serial_out_oe_b;
   logic prog_busy;
   int failures = 0;
   int n_compared = 0;
   int cycles = 0;

   eep_core #(.PROG_CYC(PROG)) u_eep_core (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .serial_clock(serial_clock),
      .chip_sel(chip_sel),
      .serial_in(serial_in),
      .serial_out(serial_out),
      .serial_out_oe_b(serial_out_oe_b),
      .prog_busy(prog_busy)
   );

   eep_host_model u_eep_host_model (
      .sys_clk(sys_clk),
      .serial_clock(serial_clock),
      .chip_sel(chip_sel),
      .serial_in(serial_in),
      .serial_out(serial_out),
      .serial_out_oe_b(serial_out_oe_b)
   );

   // System clock of 50 MHz.
   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // Hang guard, well above the few thousand cycles the tests need.
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 40000)
      begin
         failures++;
         print_verdict();
      end
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Status must not show before 1 us of select, reads busy, then ready, then is cancelled.
   task automatic prog_wait(input string what);
      int n;
      u_eep_host_model.select(1'b1);
      repeat (40) @(posedge sys_clk);
      check({what, " early oe"}, 16'(serial_out_oe_b), 16'h1);
      repeat (30) @(posedge sys_clk);
      check({what, " busy oe"}, 16'(serial_out_oe_b), 16'h0);
      check({what, " busy level"}, 16'(serial_out), 16'h0);
      n = 0;
      while (serial_out !== 1'b1 && n < 400)
      begin
         @(posedge sys_clk);
         n++;
      end
      check({what, " ready"}, 16'(serial_out), 16'h1);
      u_eep_host_model.pulse(1'b1);
      repeat (10) @(posedge sys_clk);
      check({what, " cancel"}, 16'(serial_out_oe_b), 16'h1);
      check({what, " idle"}, 16'(prog_busy), 16'h0);
      u_eep_host_model.select(1'b0);
   endtask

   // Programming instruction that must start a cycle at select fall.
   task automatic prog(input string what, input logic [24:0] bits, input int n);
      u_eep_host_model.frame(bits, n);
      check({what, " started"}, 16'(prog_busy), 16'h1);
      prog_wait(what);
   endtask

   task automatic rd(input logic [5:0] a, input logic [15:0] exp);
      logic [1:0] dummy;
      logic [15:0] word;
      logic rel_oe;
      u_eep_host_model.read(a, dummy, word, rel_oe);
      check("dummy bit", {14'h0, dummy}, 16'h0);
      check("read word", word, exp);
      check("read release", 16'(rel_oe), 16'h1);
   endtask

   // Power-up ready status is shown, then cancelled by one clock.
   task automatic t_power();
      u_eep_host_model.select(1'b1);
      repeat (70) @(posedge sys_clk);
      check("power-up oe", 16'(serial_out_oe_b), 16'h0);
      check("power-up level", 16'(serial_out), 16'h1);
      u_eep_host_model.pulse(1'b1);
      repeat (10) @(posedge sys_clk);
      check("power-up cancel", 16'(serial_out_oe_b), 16'h1);
      u_eep_host_model.select(1'b0);
      $display("test power-up done");
   endtask

   // Write, then read back at the word address and at an alias with higher address bits.
   task automatic t_write();
      u_eep_host_model.frame({16'h0, 1'b1, `EEP_OP_SPECIAL, `EEP_SUB_ENABLE, 4'h0}, 9);
      prog("write", {1'b1, `EEP_OP_WRITE, 6'h05, 16'ha5c3}, 25);
      rd(6'h05, 16'ha5c3);
      rd(6'h15, 16'ha5c3);
      check("float while shifting", 16'(u_eep_host_model.drive_seen), 16'h0);
      $display("test write done");
   endtask

   // Write-all, erase and erase-all, and a write refused while disabled.
   task automatic t_modes();
      prog("write-all", {1'b1, `EEP_OP_SPECIAL, `EEP_SUB_WRALL, 4'h0, 16'h1234}, 25);
      rd(6'h03, 16'h1234);
      prog("erase", {16'h0, 1'b1, `EEP_OP_ERASE, 6'h03}, 9);
      rd(6'h03, `EEP_ERASED);
      rd(6'h0f, 16'h1234);
      u_eep_host_model.frame({16'h0, 1'b1, `EEP_OP_SPECIAL, `EEP_SUB_DISABLE, 4'h0}, 9);
      u_eep_host_model.frame({1'b1, `EEP_OP_WRITE, 6'h04, 16'h5555}, 25);
      check("disabled write", 16'(prog_busy), 16'h0);
      rd(6'h04, 16'h1234);
      u_eep_host_model.frame({16'h0, 1'b1, `EEP_OP_SPECIAL, `EEP_SUB_ENABLE, 4'h0}, 9);
      prog("erase-all", {16'h0, 1'b1, `EEP_OP_SPECIAL, `EEP_SUB_ERALL, 4'h0}, 9);
      rd(6'h04, `EEP_ERASED);
      check("float after modes", 16'(u_eep_host_model.drive_seen), 16'h0);
      $display("test modes done");
   endtask

   // Reset in mid-programming: the cycle stops, nothing lands, and the
   // power-up status comes back until it is cancelled again.
   task automatic t_reset();
      u_eep_host_model.frame({1'b1, `EEP_OP_WRITE, 6'h06, 16'h0f0f}, 25);
      check("reset busy", 16'(prog_busy), 16'h1);
      @(posedge sys_clk);
      #1 rst_b = 1'b0;
      repeat (8) @(posedge sys_clk);
      check("reset oe", 16'(serial_out_oe_b), 16'h1);
      check("reset busy cleared", 16'(prog_busy), 16'h0);
      #1 rst_b = 1'b1;
      repeat (3) @(posedge sys_clk);
      t_power();
      rd(6'h06, `EEP_ERASED);
      $display("test reset done");
   endtask

   // Reset for 8 cycles, then the tests in order.
   initial
   begin
      rst_b = 1'b0;
      repeat (8) @(posedge sys_clk);
      #1 rst_b = 1'b1;
      repeat (3) @(posedge sys_clk);
      t_power();
      t_write();
      t_modes();
      t_reset();
      print_verdict();
   end
endmodule // eep_core_test

`default_nettype wire

/* verification/eep_host_model.sv */
// Purpose: Host model that bit-bangs the serial port of the EEPROM core.
// Assumes: Separate input and output pins; serial clock of 125 ns, running only inside frames.
// Notes: The bench calls the tasks; the clock stands low between frames.
`timescale 1ns/10ps
`default_nettype none

module eep_host_model (
   input wire logic sys_clk,
   output logic serial_clock,
   output logic chip_sel,
   output logic serial_in,
   input wire logic serial_out,
   input wire logic serial_out_oe_b
);
   int drive_seen = 0;
   logic last_oe;
   logic last_so;
   logic last_drv = 1'b0;
   logic line;
   // Shadow of the host's output port; tasks change only the three link bits
   // and the whole word goes to the port, so the other bits never move.
   logic [7:0] port_mask = 8'hc0;

   assign chip_sel = port_mask[0];
   assign serial_clock = port_mask[1];
   assign serial_in = port_mask[2];

   // Nothing pulls the data line, so once released it shows the inverse of
   // the last level driven; a sample taken after release then reads wrong.
   always @(serial_out or serial_out_oe_b)
   begin
      if (!serial_out_oe_b)
         last_drv = serial_out;
   end
   assign line = serial_out_oe_b ? ~last_drv : serial_out;

   // One clock pulse; the pin is sampled just before the next rise, so that slow data still lands.
   task automatic pulse(input logic b);
      port_mask[2] = b;
      #10 port_mask[1] = 1'b1;
      #62.5 port_mask[1] = 1'b0;
      #52.5;
      last_oe = serial_out_oe_b;
      last_so = line;
   endtask

   // Select changes just after a system edge; a low select is held past 1 us.
   task automatic select(input logic on);
      @(posedge sys_clk);
      #1 port_mask[0] = on;
      if (!on)
      begin
         port_mask[2] = ~port_mask[2];
         repeat (60) @(posedge sys_clk);
      end
   endtask

   // Whole instruction, MSB first; any drive seen on the pin meanwhile is counted.
   task automatic frame(input logic [24:0] bits, input int n);
      select(1'b1);
      for (int i = n - 1; i >= 0; i--)
      begin
         pulse(bits[i]);
         if (last_oe !== 1'b1)
            drive_seen++;
      end
      select(1'b0);
   endtask

   // Read of one word: dummy bit, sixteen data bits, then one edge that releases the pin.
   task automatic read(input logic [5:0] a, output logic [1:0] dummy, output logic [15:0] word,
                       output logic rel_oe);
      logic [8:0] cmd;
      cmd = {1'b1, `EEP_OP_READ, a};
      select(1'b1);
      for (int i = 8; i >= 0; i--)
      begin
         pulse(cmd[i]);
         if (i > 0 && last_oe !== 1'b1)
            drive_seen++;
      end
      dummy = {last_oe, last_so};
      for (int k = 15; k >= 0; k--)
      begin
         pulse(1'b0);
         word[k] = last_so;
      end
      pulse(1'b0);
      rel_oe = last_oe;
      select(1'b0);
   endtask
endmodule // eep_host_model

`default_nettype wire
